/* File: core/drc_pkg.sv */
// Constants and types for the run command and ramp block
// Function
// - Source 2 takes run and direction from terminals; range 0 to 3.
// - There the function 0 terminal runs, forward while direction is off.
// - There the function 1 terminal gives reverse while on and running.
// - Terminal functions span 0 to 27, defaulting to 0 and 1.
// - Source 3 runs from the serial link, on the advanced variant only.
// - Serial station 1 to 250 (1), protocol 0 to 1 (0), speed 0 to 4 (3).
// - Run prevention is 0 none, 1 no forward or 2 no reverse; resets 0.
// - Keypad direction steers only under source 0, always read/write.
// - Power-on run 1 starts on a terminal run held at power-up.
// - Reset-restart 1 resumes a held terminal run after a fault reset.
// - Separate ramp up and down times default to 5.0 s and 10.0 s.
// - Ramp time spans zero to max frequency, 40.00 to 400.00 Hz (60.00).
// - Time scale 0, 1, 2 gives 0.01, 0.1 or 1 s steps, default 1.
// - Ramp times hold five digits; the scale moves the point only.
// - Under source 0 the run key starts and stop key ramps to a stop.
package drc_pkg;
   // Register byte offsets
   localparam logic [7:0] DRC_OFS_CTRL = 8'h00;
   localparam logic [7:0] DRC_OFS_TERM = 8'h04;
   localparam logic [7:0] DRC_OFS_SER = 8'h08;
   localparam logic [7:0] DRC_OFS_ACC = 8'h0C;
   localparam logic [7:0] DRC_OFS_DEC = 8'h10;
   localparam logic [7:0] DRC_OFS_FMAX = 8'h14;
   localparam logic [7:0] DRC_OFS_TGT = 8'h18;
   localparam logic [7:0] DRC_OFS_STAT = 8'h1C;
   // Control, terminal and serial register field positions
   localparam int DRC_CTRL_SRC = 0;
   localparam int DRC_CTRL_KDIR = 2;
   localparam int DRC_CTRL_PREV = 4;
   localparam int DRC_CTRL_PON = 8;
   localparam int DRC_CTRL_RRS = 9;
   localparam int DRC_CTRL_REF = 12;
   localparam int DRC_CTRL_TS = 16;
   localparam int DRC_TERM2_POS = 8;
   localparam int DRC_SER_PROT = 8;
   localparam int DRC_SER_SPD = 16;
   // Reset values, limits and terminal function codes
   localparam logic [1:0] DRC_SRC_RST = 2'h1;
   localparam logic [4:0] DRC_T1_FUNC_RST = 5'h00;
   localparam logic [4:0] DRC_T2_FUNC_RST = 5'h01;
   localparam logic [4:0] DRC_FUNC_MAX = 5'h1B;
   localparam logic [4:0] DRC_FUNC_RUN = 5'h00;
   localparam logic [4:0] DRC_FUNC_DIR = 5'h01;
   localparam logic [7:0] DRC_STN_RST = 8'h01;
   localparam logic [7:0] DRC_STN_MAX = 8'hFA;
   localparam logic [2:0] DRC_SPD_RST = 3'h3;
   localparam logic [2:0] DRC_SPD_MAX = 3'h4;
   localparam logic [15:0] DRC_ACC_RST = 16'h0032;
   localparam logic [15:0] DRC_DEC_RST = 16'h0064;
   localparam logic [15:0] DRC_TIME_MAX = 16'hEA60;
   localparam logic [15:0] DRC_FMAX_RST = 16'h1770;
   localparam logic [15:0] DRC_FMAX_MIN = 16'h0FA0;
   localparam logic [15:0] DRC_FMAX_MAX = 16'h9C40;
   // Ramp tick: 10 us base, scaled per time-scale step
   localparam int DRC_CLK_NS = 4;
   localparam int DRC_TICK_NS = 10000;
   localparam int DRC_TICK_CYC = (DRC_TICK_NS + DRC_CLK_NS - 1) / DRC_CLK_NS;
   localparam logic [16:0] DRC_TICKS_TS0 = 17'h003E8;
   localparam logic [16:0] DRC_TICKS_TS1 = 17'h02710;
   localparam logic [16:0] DRC_TICKS_TS2 = 17'h186A0;
   typedef enum logic [1:0] {
      DRC_SRC_KEYPAD = 2'b00,
      DRC_SRC_FWDREV = 2'b01,
      DRC_SRC_TERM = 2'b10,
      DRC_SRC_SERIAL = 2'b11
   } drc_src_t;
   typedef enum logic [1:0] {
      DRC_PREV_NONE = 2'b00,
      DRC_PREV_FWD = 2'b01,
      DRC_PREV_REV = 2'b10
   } drc_prev_t;
   typedef enum logic [1:0] {
      DRC_TS_10MS = 2'b00,
      DRC_TS_100MS = 2'b01,
      DRC_TS_1S = 2'b10
   } drc_ts_t;
endpackage : drc_pkg

/* File: core/drc_ramp.sv */
// Linear frequency ramp toward a goal
`timescale 1ns/1ps
`default_nettype none
module drc_ramp
   import drc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic tick_in,
   input wire logic [15:0] goal_in,
   input wire logic [15:0] fmax_in,
   input wire logic [15:0] acc_time_in,
   input wire logic [15:0] dec_time_in,
   input wire drc_ts_t scale_in,
   output logic [15:0] freq_out
);
   logic [15:0] freq_r;
   logic [33:0] acc_r;
   logic [33:0] acc_nxt;
   wire rising = goal_in > freq_r;
   wire at_goal = goal_in == freq_r;
   wire [15:0] time_sel = rising ? acc_time_in : dec_time_in;
   // Ticks per time digit follow the time scale, so digits stay put
   wire [16:0] ticks_per = (scale_in == DRC_TS_10MS) ? DRC_TICKS_TS0 :
                           (scale_in == DRC_TS_1S) ? DRC_TICKS_TS2 : DRC_TICKS_TS1;
   // Full span zero to fmax takes time_sel digits
   wire [33:0] thresh = 34'(time_sel * ticks_per);
   wire step = !at_goal && (acc_r >= thresh);
   wire [33:0] acc_add = tick_in ? 34'(acc_r + 34'(fmax_in)) : acc_r;
   // Accumulator drains one 0.01 Hz step per cycle; idle at goal to avoid windup
   always_comb begin
      acc_nxt = acc_add;
      if (at_goal) begin
         acc_nxt = '0;
      end else if (step) begin
         acc_nxt = 34'(acc_add - thresh);
      end
   end
   // Zero time jumps straight to the goal
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         freq_r <= '0;
         acc_r <= '0;
      end else begin
         acc_r <= acc_nxt;
         if (time_sel == 16'h0000) begin
            freq_r <= goal_in;
         end else if (step) begin
            freq_r <= rising ? 16'(freq_r + 16'h0001) : 16'(freq_r - 16'h0001);
         end
      end
   end
   assign freq_out = freq_r;
endmodule : drc_ramp
`default_nettype wire

/* File: core/drc_top.sv */
// Run command selection, direction blocking and ramp control
`timescale 1ns/1ps
`default_nettype none
module drc_top
   import drc_pkg::*;
#(
   parameter bit ADV_IO = 1'b1,
   parameter int NUM_TERM = 2
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [7:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [NUM_TERM-1:0] input_terminal_in,
   input wire logic keypad_run_key_in,
   input wire logic keypad_stop_key_in,
   input wire logic serial_run_in,
   input wire logic serial_reverse_in,
   input wire logic fault_trip_in,
   input wire logic fault_reset_in,
   output logic running_out,
   output logic reverse_out,
   output logic blocked_out,
   output logic [15:0] out_freq_out
);
   // Settings
   drc_src_t cmd_source_r;
   logic keypad_direction_select_r;
   drc_prev_t run_prevention_select_r;
   logic power_on_run_enable_r;
   logic reset_restart_enable_r;
   logic ramp_reference_select_r;
   drc_ts_t ramp_time_scale_r;
   logic [4:0] terminal1_function_select_r;
   logic [4:0] terminal2_function_select_r;
   logic [7:0] station_r;
   logic protocol_r;
   logic [2:0] speed_r;
   logic [15:0] acc_time_r;
   logic [15:0] dec_time_r;
   logic [15:0] max_output_frequency_r;
   logic [15:0] target_r;
   // Bus and run state
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic keypad_run_r;
   logic term_prev_r;
   logic term_armed_r;
   logic tripped_r;
   logic reverse_r;
   logic running_r;
   logic blocked_r;
   logic [15:0] out_freq_r;
   logic [11:0] tick_cnt_r;
   logic tick_r;
   logic [15:0] ramp_freq;

   // Bus address phase decode and data phase write strobes
   wire addr_ok = hsel_in && hready_in && htrans_in[1];
   wire rd_take = addr_ok && !hwrite_in;
   wire wr_take = addr_ok && hwrite_in;
   wire wr_ctrl = wr_pend_r && (wr_addr_r == DRC_OFS_CTRL);
   wire wr_term = wr_pend_r && (wr_addr_r == DRC_OFS_TERM);
   wire wr_ser = wr_pend_r && (wr_addr_r == DRC_OFS_SER);
   wire wr_acc = wr_pend_r && (wr_addr_r == DRC_OFS_ACC);
   wire wr_dec = wr_pend_r && (wr_addr_r == DRC_OFS_DEC);
   wire wr_fmax = wr_pend_r && (wr_addr_r == DRC_OFS_FMAX);
   wire wr_tgt = wr_pend_r && (wr_addr_r == DRC_OFS_TGT);

   // Written fields; out-of-range values leave the old setting in place
   wire [1:0] w_prev = hwdata_in[DRC_CTRL_PREV +: 2];
   wire [1:0] w_ts = hwdata_in[DRC_CTRL_TS +: 2];
   wire [4:0] w_f1 = hwdata_in[4:0];
   wire [4:0] w_f2 = hwdata_in[DRC_TERM2_POS +: 5];
   wire [7:0] w_stn = hwdata_in[7:0];
   wire [2:0] w_spd = hwdata_in[DRC_SER_SPD +: 3];
   wire [15:0] w_16 = hwdata_in[15:0];
   wire prev_ok = w_prev != 2'h3;
   wire ts_ok = w_ts != 2'h3;
   wire f1_ok = w_f1 <= DRC_FUNC_MAX;
   wire f2_ok = w_f2 <= DRC_FUNC_MAX;
   wire stn_ok = (w_stn != 8'h00) && (w_stn <= DRC_STN_MAX);
   wire spd_ok = w_spd <= DRC_SPD_MAX;
   wire time_ok = w_16 <= DRC_TIME_MAX;
   wire fmax_ok = (w_16 >= DRC_FMAX_MIN) && (w_16 <= DRC_FMAX_MAX);

   // Read mux, unmapped offsets read zero
   wire [31:0] rd_ctrl = {14'h0000, ramp_time_scale_r, 3'h0, ramp_reference_select_r, 2'h0,
                          reset_restart_enable_r, power_on_run_enable_r, 2'h0,
                          run_prevention_select_r, 1'b0, keypad_direction_select_r, cmd_source_r};
   wire [31:0] rd_term = {19'h00000, terminal2_function_select_r, 3'h0, terminal1_function_select_r};
   wire [31:0] rd_ser = {13'h0000, speed_r, 7'h00, protocol_r, station_r};
   wire [31:0] rd_stat = {out_freq_r, 11'h000, tripped_r, blocked_r, reverse_r, 1'b0, running_r};
   wire [31:0] rd_mux = (haddr_in == DRC_OFS_CTRL) ? rd_ctrl :
                        (haddr_in == DRC_OFS_TERM) ? rd_term :
                        (haddr_in == DRC_OFS_SER) ? rd_ser :
                        (haddr_in == DRC_OFS_ACC) ? {16'h0000, acc_time_r} :
                        (haddr_in == DRC_OFS_DEC) ? {16'h0000, dec_time_r} :
                        (haddr_in == DRC_OFS_FMAX) ? {16'h0000, max_output_frequency_r} :
                        (haddr_in == DRC_OFS_TGT) ? {16'h0000, target_r} :
                        (haddr_in == DRC_OFS_STAT) ? rd_stat : 32'h00000000;

   // Bus slave: zero wait states, OKAY only, write lands in the data phase
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
         hreadyout_r <= 1'b1;
      end else begin
         hreadyout_r <= 1'b1;
         if (hready_in) begin
            wr_pend_r <= wr_take;
            wr_addr_r <= haddr_in;
         end
         if (rd_take) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   // Settings registers with documented reset values
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cmd_source_r <= drc_src_t'(DRC_SRC_RST);
         keypad_direction_select_r <= 1'b0;
         run_prevention_select_r <= DRC_PREV_NONE;
         power_on_run_enable_r <= 1'b0;
         reset_restart_enable_r <= 1'b0;
         ramp_reference_select_r <= 1'b0;
         ramp_time_scale_r <= DRC_TS_100MS;
      end else if (wr_ctrl) begin
         // Selector 0..3 all legal; keypad direction writable under any source
         cmd_source_r <= drc_src_t'(hwdata_in[DRC_CTRL_SRC +: 2]);
         keypad_direction_select_r <= hwdata_in[DRC_CTRL_KDIR];
         if (prev_ok) begin
            run_prevention_select_r <= drc_prev_t'(w_prev);
         end
         power_on_run_enable_r <= hwdata_in[DRC_CTRL_PON];
         reset_restart_enable_r <= hwdata_in[DRC_CTRL_RRS];
         ramp_reference_select_r <= hwdata_in[DRC_CTRL_REF];
         if (ts_ok) begin
            ramp_time_scale_r <= drc_ts_t'(w_ts);
         end
      end
   end

   // Terminal functions and serial settings
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         terminal1_function_select_r <= DRC_T1_FUNC_RST;
         terminal2_function_select_r <= DRC_T2_FUNC_RST;
         station_r <= DRC_STN_RST;
         protocol_r <= 1'b0;
         speed_r <= DRC_SPD_RST;
      end else begin
         if (wr_term && f1_ok) begin
            terminal1_function_select_r <= w_f1;
         end
         if (wr_term && f2_ok) begin
            terminal2_function_select_r <= w_f2;
         end
         if (wr_ser && stn_ok) begin
            station_r <= w_stn;
         end
         if (wr_ser) begin
            protocol_r <= hwdata_in[DRC_SER_PROT];
         end
         if (wr_ser && spd_ok) begin
            speed_r <= w_spd;
         end
      end
   end

   // Ramp times and frequencies; digits stored raw, scale applied in the ramp
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         acc_time_r <= DRC_ACC_RST;
         dec_time_r <= DRC_DEC_RST;
         max_output_frequency_r <= DRC_FMAX_RST;
         target_r <= 16'h0000;
      end else begin
         if (wr_acc && time_ok) begin
            acc_time_r <= w_16;
         end
         if (wr_dec && time_ok) begin
            dec_time_r <= w_16;
         end
         if (wr_fmax && fmax_ok) begin
            max_output_frequency_r <= w_16;
         end
         if (wr_tgt) begin
            target_r <= w_16;
         end
      end
   end

   // Terminal function decode, one slice per terminal
   logic [4:0] term_func [NUM_TERM];
   logic [NUM_TERM-1:0] run_hit;
   logic [NUM_TERM-1:0] dir_hit;
   assign term_func[0] = terminal1_function_select_r;
   assign term_func[1] = terminal2_function_select_r;
   for (genvar i = 0; i < NUM_TERM; i++) begin : g_term
      assign run_hit[i] = input_terminal_in[i] && (term_func[i] == DRC_FUNC_RUN);
      assign dir_hit[i] = input_terminal_in[i] && (term_func[i] == DRC_FUNC_DIR);
   end
   wire run_terminal_function = |run_hit;
   wire term_dir = |dir_hit;

   // Source selection; fwd/rev two-terminal mode is not built and requests no run
   wire src_key = cmd_source_r == DRC_SRC_KEYPAD;
   wire src_term = cmd_source_r == DRC_SRC_TERM;
   wire src_ser = (cmd_source_r == DRC_SRC_SERIAL) && ADV_IO;
   wire term_rise = run_terminal_function && !term_prev_r;
   wire term_run = src_term && run_terminal_function && term_armed_r;
   wire req_run = !tripped_r && ((src_key && keypad_run_r) || term_run || (src_ser && serial_run_in));
   // Direction: keypad setting only counts under the keypad source
   wire req_rev = src_key ? keypad_direction_select_r :
                  src_term ? term_dir :
                  src_ser ? serial_reverse_in : 1'b0;
   wire req_block = req_run && ((run_prevention_select_r == DRC_PREV_FWD && !req_rev) ||
                                (run_prevention_select_r == DRC_PREV_REV && req_rev));
   wire [15:0] tgt_lim = (target_r > max_output_frequency_r) ? max_output_frequency_r : target_r;
   // Reversal ramps to zero first, then flips
   wire dir_wrong = req_rev != reverse_r;
   wire [15:0] goal = (req_run && !req_block && !dir_wrong) ? tgt_lim : 16'h0000;

   // Keypad run latch and fault state; a new trip wins over a same-cycle reset
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         keypad_run_r <= 1'b0;
         tripped_r <= 1'b0;
      end else begin
         if (fault_trip_in || tripped_r || !src_key || keypad_stop_key_in) begin
            keypad_run_r <= 1'b0;
         end else if (keypad_run_key_in) begin
            keypad_run_r <= 1'b1;
         end
         if (fault_trip_in) begin
            tripped_r <= 1'b1;
         end else if (fault_reset_in) begin
            tripped_r <= 1'b0;
         end
      end
   end

   // Terminal arming: a level held since power-up counts only with power-on run,
   // and one held through a trip only with reset-restart or power-on run
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         term_prev_r <= 1'b1;
         term_armed_r <= 1'b0;
      end else begin
         term_prev_r <= run_terminal_function;
         if (!run_terminal_function) begin
            term_armed_r <= 1'b0;
         end else if (fault_trip_in && !reset_restart_enable_r) begin
            term_armed_r <= 1'b0;
         end else if (term_rise || power_on_run_enable_r || (tripped_r && reset_restart_enable_r)) begin
            term_armed_r <= 1'b1;
         end
      end
   end

   // Ramp tick divider, one-cycle enable every 10 us
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         tick_cnt_r <= 12'h000;
         tick_r <= 1'b0;
      end else begin
         tick_r <= tick_cnt_r == 12'(DRC_TICK_CYC - 1);
         tick_cnt_r <= (tick_cnt_r == 12'(DRC_TICK_CYC - 1)) ? 12'h000 : 12'(tick_cnt_r + 12'h001);
      end
   end

   drc_ramp u_ramp (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .tick_in(tick_r),
      .goal_in(goal),
      .fmax_in(max_output_frequency_r),
      .acc_time_in(acc_time_r),
      .dec_time_in(dec_time_r),
      .scale_in(ramp_time_scale_r),
      .freq_out(ramp_freq)
   );

   // Run status; direction only flips at standstill
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         reverse_r <= 1'b0;
         running_r <= 1'b0;
         blocked_r <= 1'b0;
         out_freq_r <= 16'h0000;
      end else begin
         out_freq_r <= ramp_freq;
         blocked_r <= req_block;
         running_r <= (ramp_freq != 16'h0000) || (goal != 16'h0000);
         if (ramp_freq == 16'h0000 && req_run && !req_block) begin
            reverse_r <= req_rev;
         end
      end
   end

   assign hrdata_out = hrdata_r;
   assign hreadyout_out = hreadyout_r;
   assign hresp_out = 1'b0;
   assign running_out = running_r;
   assign reverse_out = reverse_r;
   assign blocked_out = blocked_r;
   assign out_freq_out = out_freq_r;
endmodule : drc_top
`default_nettype wire

/* File: verification/drc_field_model.sv */
// Far-side stand-in: input terminals, keypad keys, serial link and fault source
`timescale 1ns/1ps
`default_nettype none
module drc_field_model (
   input wire logic clk_sys_in,
   input wire logic [1:0] term_req_in,
   input wire logic [1:0] ser_req_in,
   input wire logic [3:0] btn_req_in,
   output logic [1:0] term_out,
   output logic ser_run_out,
   output logic ser_rev_out,
   output logic [3:0] btn_out
);
   logic [3:0] btn_q_r;
   // Levels pass through one flop, like a filtered terminal; keys give one pulse per press
   always_ff @(posedge clk_sys_in) begin
      term_out <= term_req_in; // Bit 0 run, bit 1 reverse
      ser_run_out <= ser_req_in[0];
      ser_rev_out <= ser_req_in[1];
      btn_q_r <= btn_req_in;
      btn_out <= btn_req_in & ~btn_q_r; // Run, stop, trip, clear events
   end
endmodule : drc_field_model
`default_nettype wire

/* File: verification/drc_top_chk.sv */
// Concurrent checks on bus readback and run outputs
`timescale 1ns/1ps
`default_nettype none
module drc_top_chk
   import drc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [7:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_out,
   input wire logic fault_trip_in,
   input wire logic fault_reset_in,
   input wire logic running_out,
   input wire logic reverse_out,
   input wire logic blocked_out,
   input wire logic [15:0] out_freq_out
);
   default clocking dcb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   // Read request taken on this edge
   wire logic rd_w = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
   a_ctrl_fields: assert property (
      rd_w && haddr_in == DRC_OFS_CTRL |=> hrdata_out[31:18] == 14'h0000
      && hrdata_out[17:16] != 2'h3 && hrdata_out[5:4] != 2'h3 && !hrdata_out[3])
      else $error("bad ctrl field");
   a_term_fields: assert property (
      rd_w && haddr_in == DRC_OFS_TERM |=> hrdata_out[31:13] == 19'h00000
      && hrdata_out[7:5] == 3'h0 && hrdata_out[4:0] <= 5'h1B)
      else $error("bad term func");
   a_time_digits: assert property (
      rd_w && (haddr_in == DRC_OFS_ACC || haddr_in == DRC_OFS_DEC)
      |=> hrdata_out[31:16] == 16'h0000 && hrdata_out[15:0] <= 16'hEA60)
      else $error("time over max");
   a_stat_mirror: assert property (
      rd_w && haddr_in == DRC_OFS_STAT |=> hrdata_out[0] == $past(running_out)
      && hrdata_out[3:2] == {$past(blocked_out), $past(reverse_out)})
      else $error("status mismatch");
   a_flip_at_zero: assert property (
      $changed(reverse_out) |-> ##[0:1] out_freq_out == 16'h0000)
      else $error("flip while turning");
   a_blocked_hold: assert property (
      blocked_out [*3] |-> out_freq_out <= $past(out_freq_out))
      else $error("rise while blocked");
   a_trip_hold: assert property (
      fault_trip_in ##1 !fault_reset_in [*4] |-> out_freq_out <= $past(out_freq_out))
      else $error("rise while tripped");
   a_run_flag: assert property (
      out_freq_out != 16'h0000 && $past(out_freq_out) != 16'h0000 |-> running_out)
      else $error("no running flag");
   c_run: cover property ($rose(running_out));
   c_rev: cover property ($rose(reverse_out));
   c_blk: cover property ($rose(blocked_out));
endmodule : drc_top_chk
bind drc_top drc_top_chk chk_u (.*);
`default_nettype wire

/* File: verification/drive_run_command_and_ramp_timing_tb.sv */
// Self-checking bench for run command selection and ramp timing
`timescale 1ns/1ps
`default_nettype none
module drive_run_command_and_ramp_timing_tb
   import drc_pkg::*;
();
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] term_req = 2'h0;
   logic [1:0] ser_req = 2'h0;
   logic [3:0] btn_req = 4'h0;
   wire logic [31:0] hrdata;
   wire logic hrdy, hresp, running, reverse, blocked, ser_run, ser_rev;
   wire logic [15:0] freq;
   wire logic [1:0] term;
   wire logic [3:0] btn;
   int num_errors = 0;
   int cmp_count = 0;
   // 250 MHz
   always #2 clk_sys_in = ~clk_sys_in;
   drc_top dut_u (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
      .input_terminal_in(term), .keypad_run_key_in(btn[0]), .keypad_stop_key_in(btn[1]),
      .serial_run_in(ser_run), .serial_reverse_in(ser_rev), .fault_trip_in(btn[2]),
      .fault_reset_in(btn[3]), .running_out(running), .reverse_out(reverse),
      .blocked_out(blocked), .out_freq_out(freq)
   );
   drc_field_model field_u (
      .clk_sys_in(clk_sys_in), .term_req_in(term_req), .ser_req_in(ser_req),
      .btn_req_in(btn_req), .term_out(term), .ser_run_out(ser_run),
      .ser_rev_out(ser_rev), .btn_out(btn)
   );
   task automatic print_verdict;
      $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One bus phase; bounded so a stuck slave ends the run
   task automatic bus_edge;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (hrdy !== 1'b1 && n < 64);
      if (hrdy !== 1'b1) begin
         num_errors++;
         print_verdict();
      end
   endtask : bus_edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_sys_in);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      bus_edge();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      bus_edge();
      q = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(nm, q, exp);
      chk("hresp", 32'(hresp), 32'h0);
   endtask : rdc
   task automatic wrc(input string nm, input logic [7:0] a, input logic [31:0] d, e);
      wr(a, d);
      rdc(nm, a, e);
   endtask : wrc
   function automatic logic [31:0] ctrl(int s, kd, pv, pon, rrs, ts);
      return (32'(s) << DRC_CTRL_SRC) | (32'(kd) << DRC_CTRL_KDIR)
         | (32'(pv) << DRC_CTRL_PREV) | (32'(pon) << DRC_CTRL_PON)
         | (32'(rrs) << DRC_CTRL_RRS) | (32'(ts) << DRC_CTRL_TS);
   endfunction : ctrl
   // Wait, bounded, for a settled output state, then compare it
   task automatic wst(input logic [15:0] f, input logic rv, input logic bl);
      int n;
      n = 0;
      while ((freq !== f || reverse !== rv || blocked !== bl) && n < 400) begin
         @(posedge clk_sys_in);
         n++;
      end
      chk("freq", 32'(freq), 32'(f));
      chk("reverse", 32'(reverse), 32'(rv));
      chk("blocked", 32'(blocked), 32'(bl));
      chk("running", 32'(running), 32'(f != 16'h0000));
      if (n >= 400)
         print_verdict();
   endtask : wst
   task automatic press(input int b);
      btn_req[b] <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      btn_req[b] <= 1'b0;
      @(posedge clk_sys_in);
   endtask : press
   task automatic setup(input logic [15:0] acc);
      wr(DRC_OFS_FMAX, 32'h9C40);
      wr(DRC_OFS_TGT, 32'h64);
      wr(DRC_OFS_ACC, 32'(acc));
      wr(DRC_OFS_DEC, 32'h0);
   endtask : setup
   // Ramp from rest, band of cycles from tick phase uncertainty
   task automatic tramp(input logic [15:0] f, input int lo, input int hi);
      int n;
      n = 0;
      term_req <= 2'b01;
      while (freq !== f && n < 20000) begin
         @(posedge clk_sys_in);
         n++;
      end
      chk("ramp_cycles", 32'(n >= lo && n <= hi), 32'h1);
      term_req <= 2'b00;
      wst(16'h0000, 1'b0, 1'b0);
   endtask : tramp
   initial begin
      repeat (3) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      rdc("ctrl", DRC_OFS_CTRL, 32'h10001);
      rdc("term", DRC_OFS_TERM, 32'h100);
      rdc("ser", DRC_OFS_SER, 32'h30001);
      rdc("acc", DRC_OFS_ACC, 32'h32);
      rdc("dec", DRC_OFS_DEC, 32'h64);
      rdc("fmax", DRC_OFS_FMAX, 32'h1770);
      rdc("hole", 8'h20, 32'h0);
      $display("test reset done");
      wrc("bad_mode", DRC_OFS_CTRL, ctrl(1, 0, 3, 0, 0, 3), 32'h10001);
      for (int i = 0; i < 3; i++) begin
         wrc("modes", DRC_OFS_CTRL, ctrl(1, 0, i, 0, 0, i), ctrl(1, 0, i, 0, 0, i));
      end
      wrc("func", DRC_OFS_TERM, 32'h1C1B, 32'h11B);
      wr(DRC_OFS_TERM, 32'h100);
      wrc("station", DRC_OFS_SER, 32'h401FB, 32'h40101);
      wrc("speed", DRC_OFS_SER, 32'h501FA, 32'h401FA);
      wrc("acc_over", DRC_OFS_ACC, 32'hEA61, 32'h32);
      wrc("acc_max", DRC_OFS_ACC, 32'hEA60, 32'hEA60);
      $display("test limits done");
      setup(16'h0);
      wr(DRC_OFS_CTRL, ctrl(2, 1, 0, 0, 0, 0));
      term_req <= 2'b01;
      wst(16'h64, 1'b0, 1'b0);
      term_req <= 2'b11;
      wst(16'h64, 1'b1, 1'b0);
      wr(DRC_OFS_CTRL, ctrl(2, 1, 2, 0, 0, 0));
      wst(16'h0, 1'b1, 1'b1);
      rdc("stat", DRC_OFS_STAT, 32'hC);
      wr(DRC_OFS_CTRL, ctrl(2, 1, 1, 0, 0, 0));
      wst(16'h64, 1'b1, 1'b0);
      term_req <= 2'b00;
      wst(16'h0, 1'b1, 1'b0);
      $display("test terminals done");
      wr(DRC_OFS_CTRL, ctrl(0, 0, 0, 0, 0, 0));
      press(0);
      wst(16'h64, 1'b0, 1'b0);
      press(1);
      wst(16'h0, 1'b0, 1'b0);
      wr(DRC_OFS_CTRL, ctrl(3, 0, 0, 0, 0, 0));
      ser_req <= 2'b11;
      wst(16'h64, 1'b1, 1'b0);
      ser_req <= 2'b00;
      wst(16'h0, 1'b1, 1'b0);
      $display("test keypad serial done");
      wr(DRC_OFS_CTRL, ctrl(2, 0, 0, 0, 0, 0));
      term_req <= 2'b01;
      wst(16'h64, 1'b0, 1'b0);
      press(2);
      wst(16'h0, 1'b0, 1'b0);
      rdc("tripped", DRC_OFS_STAT, 32'h10);
      press(3);
      repeat (100) @(posedge clk_sys_in);
      wst(16'h0, 1'b0, 1'b0);
      term_req <= 2'b00;
      repeat (4) @(posedge clk_sys_in);
      term_req <= 2'b01;
      wst(16'h64, 1'b0, 1'b0);
      wr(DRC_OFS_CTRL, ctrl(2, 0, 0, 0, 1, 0));
      press(2);
      wst(16'h0, 1'b0, 1'b0);
      press(3);
      wst(16'h64, 1'b0, 1'b0);
      $display("test restart done");
      // Reset mid-run with the run terminal still held
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      setup(16'h0);
      wr(DRC_OFS_CTRL, ctrl(2, 0, 0, 0, 0, 0));
      repeat (100) @(posedge clk_sys_in);
      wst(16'h0, 1'b0, 1'b0);
      wr(DRC_OFS_CTRL, ctrl(2, 0, 0, 1, 0, 0));
      wst(16'h64, 1'b0, 1'b0);
      term_req <= 2'b00;
      $display("test power on done");
      setup(16'h1);
      wr(DRC_OFS_CTRL, ctrl(2, 0, 0, 0, 0, 0));
      wst(16'h0, 1'b0, 1'b0);
      tramp(16'h64, 4900, 7700);
      wr(DRC_OFS_TGT, 32'hC8);
      tramp(16'hC8, 9900, 12700);
      $display("test ramp done");
      print_verdict();
   end
endmodule : drive_run_command_and_ramp_timing_tb
`default_nettype wire
